// file: logic/usc_map.vh
// offsets, fields, reset values and timing counts of the uart block
// assumes a 32-bit apb slave, one register per aligned word
// Operation
// - idle invert sets output idle level only with encoder on
// - send break makes next frame start, twelve zeros, then stop
// - hardware clears send break after the break frame
// - tx enable with port enable gives the pin to the port, else gpio
// - clearing tx enable aborts sending and empties the buffer
// - read-only buffer-full flag shows no room for another character
// - shift-empty flag is one only when shifter and buffer are both empty
// - shift-empty reads zero while a character shifts or waits
// - rx mode 11 interrupts when a transfer makes the buffer hold four
// - rx mode 10 interrupts when a transfer leaves three characters
// - rx mode 0x interrupts on every transfer into the receive buffer
`ifndef USC_MAP_VH
`define USC_MAP_VH
// ----------------------------------------------------------------
// offsets
// ----------------------------------------------------------------
`define USC_OFS_STA      12'h000
`define USC_OFS_TXDATA   12'h004
`define USC_OFS_RXDATA   12'h008
`define USC_OFS_IRQ_STAT 12'h00c
`define USC_OFS_IRQ_MASK 12'h010
`define USC_OFS_CTRL     12'h014
// ----------------------------------------------------------------
// status/control fields
// ----------------------------------------------------------------
`define USC_B_TXI_HI  15
`define USC_B_TXINV   14
`define USC_B_TXI_LO  13
`define USC_B_BRK     11
`define USC_B_TXEN    10
`define USC_B_TXBF    9
`define USC_B_TX_SHIFT_EMPTY    8
`define USC_B_RXI_HI  7
`define USC_B_RXI_LO  6
`define USC_B_ADDRESS_DETECT_ENABLE   5
`define USC_B_RECEIVER_IDLE   4
`define USC_B_PARITY_ERROR    3
`define USC_B_FRAMING_ERROR    2
`define USC_B_OVERRUN_ERROR    1
`define USC_B_RXDA    0
`define USC_STA_RESET 16'h0110
// ctrl register bits
`define USC_B_PEN     0
`define USC_B_INFRARED_ENCODER_ON    1
// irq status bits
`define USC_I_TX      0
`define USC_I_RX      1
// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define USC_CLK_HZ    100000000
`define USC_BAUD      115200
`define USC_BIT_CYC   (`USC_CLK_HZ / `USC_BAUD)
`define USC_BRK_ZEROS 12
`endif

// file: logic/usc_rxbuf.v
// four-deep receive character buffer with fill count
// assumes one pusher and one popper
`timescale 1ns/10ps
module usc_rxbuf #(
    parameter DEPTH = 4
) (
    input  wire       pclk,
    input  wire       presetn,
    input  wire       push,
    input  wire [7:0] push_data,
    input  wire       pop,
    output wire [7:0] head,
    output reg  [2:0] count,
    output wire       full
);
    reg [7:0] mem [0:DEPTH-1];
    reg [1:0] wp, rp;
    wire do_push = push & ~full;
    wire do_pop  = pop & (count != 3'h0);
    assign full = (count == DEPTH[2:0]);
    assign head = mem[rp];
    always @(posedge pclk) begin
        if (do_push) begin
            mem[wp] <= push_data;
        end
    end
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wp    <= 2'h0;
            rp    <= 2'h0;
            count <= 3'h0;
        end else begin
            if (do_push) begin
                wp <= wp + 2'h1;
            end
            if (do_pop) begin
                rp <= rp + 2'h1;
            end
            count <= count + {2'h0, do_push} - {2'h0, do_pop};
        end
    end
endmodule // usc_rxbuf

// file: logic/usc_tick.v
// bit-rate enable divider
// assumes one clock; clr restarts a full bit
`timescale 1ns/10ps
module usc_tick #(
    parameter DIV = 868
) (
    input  wire pclk,
    input  wire presetn,
    input  wire clr,
    output reg  tick
);
    reg [15:0] cnt;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt  <= 16'h0000;
            tick <= 1'b0;
        end else if (clr) begin
            cnt  <= 16'h0001;
            tick <= 1'b0;
        end else if (cnt == DIV[15:0] - 16'h0001) begin
            cnt  <= 16'h0000;
            tick <= 1'b1;
        end else begin
            cnt  <= cnt + 16'h0001;
            tick <= 1'b0;
        end
    end
endmodule // usc_tick

// file: logic/usc_uart.v
// uart status/control with transmitter, receiver and apb slave
// assumes apb on pclk; serial input synchronous
`timescale 1ns/10ps
`include "usc_map.vh"
module usc_uart #(
    parameter BIT_CYC  = `USC_BIT_CYC,
    parameter TX_DEPTH = 4
) (
    input  wire        pclk,
    input  wire        presetn,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output wire        pready,
    output wire        pslverr,
    input  wire        serial_in_pin,
    input  wire        gpio_out,
    output wire        serial_out_pin,
    output wire        irq
);
    // ----------------------------------------------------------------
    // bus decode
    // ----------------------------------------------------------------
    wire acc   = psel & penable;
    wire wr    = acc & pwrite;
    wire rd    = acc & ~pwrite;
    wire hit_sta  = (paddr == `USC_OFS_STA);
    wire hit_txd  = (paddr == `USC_OFS_TXDATA);
    wire hit_rxd  = (paddr == `USC_OFS_RXDATA);
    wire hit_ist  = (paddr == `USC_OFS_IRQ_STAT);
    wire hit_imk  = (paddr == `USC_OFS_IRQ_MASK);
    wire hit_ctl  = (paddr == `USC_OFS_CTRL);
    wire mapped   = hit_sta | hit_txd | hit_rxd | hit_ist | hit_imk | hit_ctl;
    assign pready  = 1'b1;
    assign pslverr = acc & ~mapped;

    // ----------------------------------------------------------------
    // control bits
    // ----------------------------------------------------------------
    reg [1:0] tx_irq_mode;
    reg       tx_idle_invert;
    reg       send_break;
    reg       tx_enable;
    reg [1:0] rx_irq_mode;
    reg       address_detect_enable, overrun_error;
    reg       port_enable, infrared_encoder_on;
    reg [1:0] irq_stat, irq_mask;

    // ----------------------------------------------------------------
    // transmit buffer
    // ----------------------------------------------------------------
    reg [7:0] tx_mem [0:TX_DEPTH-1];
    reg [1:0] tx_wp, tx_rp;
    reg [2:0] tx_cnt;
    wire tx_buffer_full = (tx_cnt == TX_DEPTH[2:0]);

    // transmitter states
    localparam [3:0] S_IDLE  = 4'b0001;
    localparam [3:0] S_START = 4'b0010;
    localparam [3:0] S_DATA  = 4'b0100;
    localparam [3:0] S_STOP  = 4'b1000;
    reg [3:0] tx_state;
    reg [7:0] tx_shift_register;
    reg [3:0] tx_bits;
    reg       tx_is_break, tx_line;
    wire      tx_tick;
    wire      tx_busy = ~tx_state[0];
    wire      tx_load = tx_enable & port_enable & tx_state[0] & (tx_cnt != 3'h0);
    wire      tx_done = tx_state[3] & tx_tick;
    wire      tx_shift_empty = ~tx_busy & (tx_cnt == 3'h0);
    wire      tx_push = wr & hit_txd & tx_enable & ~tx_buffer_full;

    usc_tick #(
        .DIV     (BIT_CYC)
    ) u_txtick (
        .pclk    (pclk),
        .presetn (presetn),
        .clr     (tx_state[0]),
        .tick    (tx_tick)
    );

    always @(posedge pclk) begin
        if (tx_push) begin
            tx_mem[tx_wp] <= pwdata[7:0];
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_wp             <= 2'h0;
            tx_rp             <= 2'h0;
            tx_cnt            <= 3'h0;
            tx_state          <= S_IDLE;
            tx_shift_register <= 8'h00;
            tx_bits           <= 4'h0;
            tx_is_break       <= 1'b0;
            tx_line           <= 1'b1;
        end else if (!tx_enable) begin
            tx_wp    <= 2'h0;
            tx_rp    <= 2'h0;
            tx_cnt   <= 3'h0;
            tx_state <= S_IDLE;
            tx_line  <= 1'b1;
        end else begin
            if (tx_push) begin
                tx_wp <= tx_wp + 2'h1;
            end
            if (tx_load) begin
                tx_rp <= tx_rp + 2'h1;
            end
            tx_cnt <= tx_cnt + {2'h0, tx_push} - {2'h0, tx_load};
            case (tx_state)
                S_IDLE: begin
                    if (tx_load) begin
                        tx_is_break       <= send_break;
                        tx_shift_register <= send_break ? 8'h00 : tx_mem[tx_rp];
                        tx_state          <= S_START;
                        tx_line           <= 1'b0;
                    end
                end
                S_START: begin
                    if (tx_tick) begin
                        tx_state <= S_DATA;
                        tx_bits  <= 4'h0;
                        tx_line  <= tx_shift_register[0];
                    end
                end
                S_DATA: begin
                    if (tx_tick) begin
                        if (tx_is_break ? (tx_bits == 4'd11) : (tx_bits == 4'd7)) begin
                            tx_state <= S_STOP;
                            tx_line  <= 1'b1;
                        end else begin
                            tx_bits           <= tx_bits + 4'h1;
                            tx_shift_register <= {1'b0, tx_shift_register[7:1]};
                            tx_line           <= tx_is_break ? 1'b0 : tx_shift_register[1];
                        end
                    end
                end
                S_STOP: begin
                    if (tx_tick) begin
                        tx_state <= S_IDLE;
                    end
                end
                default: begin
                    tx_state <= S_IDLE;
                end
            endcase
        end
    end

    wire idle_flip = infrared_encoder_on & tx_idle_invert;
    assign serial_out_pin = (tx_enable & port_enable) ? (tx_line ^ idle_flip) : gpio_out;

    // ----------------------------------------------------------------
    // receiver
    // ----------------------------------------------------------------
    localparam [2:0] R_IDLE = 3'b001;
    localparam [2:0] R_DATA = 3'b010;
    localparam [2:0] R_STOP = 3'b100;
    reg  [2:0] rx_state;
    reg  [7:0] rx_shift_register;
    reg  [3:0] rx_bits;
    reg  [15:0] rx_cnt;
    reg        framing_error, rx_push;
    wire [7:0] rx_head;
    wire [2:0] rx_count;
    wire       rx_full;
    wire       receiver_idle = rx_state[0];
    wire       rx_data_available = (rx_count != 3'h0);
    wire       rx_pop = rd & hit_rxd;
    wire [15:0] half_cyc = BIT_CYC[16:1];

    usc_rxbuf #(
        .DEPTH     (4)
    ) u_rxbuf (
        .pclk      (pclk),
        .presetn   (presetn),
        .push      (rx_push),
        .push_data (rx_shift_register),
        .pop       (rx_pop),
        .head      (rx_head),
        .count     (rx_count),
        .full      (rx_full)
    );

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_state          <= R_IDLE;
            rx_shift_register <= 8'h00;
            rx_bits           <= 4'h0;
            rx_cnt            <= 16'h0000;
            framing_error     <= 1'b0;
            rx_push           <= 1'b0;
        end else begin
            rx_push <= 1'b0;
            case (rx_state)
                R_IDLE: begin
                    rx_bits <= 4'h0;
                    if (port_enable & ~serial_in_pin) begin
                        rx_state <= R_DATA;
                        rx_cnt   <= BIT_CYC[15:0] + half_cyc;
                    end
                end
                R_DATA: begin
                    if (rx_cnt == 16'h0000) begin
                        rx_shift_register <= {serial_in_pin, rx_shift_register[7:1]};
                        rx_cnt            <= BIT_CYC[15:0] - 16'h0001;
                        rx_bits           <= rx_bits + 4'h1;
                        if (rx_bits == 4'h7) begin
                            rx_state <= R_STOP;
                        end
                    end else begin
                        rx_cnt <= rx_cnt - 16'h0001;
                    end
                end
                R_STOP: begin
                    if (rx_cnt == 16'h0000) begin
                        framing_error <= ~serial_in_pin;
                        rx_push       <= 1'b1;
                        rx_state      <= R_IDLE;
                    end else begin
                        rx_cnt <= rx_cnt - 16'h0001;
                    end
                end
                default: begin
                    rx_state <= R_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // interrupt events
    // ----------------------------------------------------------------
    wire rx_take = rx_push & ~rx_full;
    reg  rx_event, tx_event;
    always @* begin
        case (rx_irq_mode)
            2'b11: rx_event = rx_take & (rx_count == 3'h3) & ~rx_pop;
            2'b10: rx_event = rx_take & (rx_count == (rx_pop ? 3'h3 : 3'h2));
            default: rx_event = rx_take;
        endcase
    end
    always @* begin
        case (tx_irq_mode)
            2'b10:   tx_event = tx_load & (tx_cnt == 3'h1) & ~tx_push;
            2'b01:   tx_event = tx_done & (tx_cnt == 3'h0) & ~tx_push;
            2'b00:   tx_event = tx_load;
            default: tx_event = 1'b0;
        endcase
    end
    assign irq = |(irq_stat & irq_mask);

    // ----------------------------------------------------------------
    // register writes
    // ----------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_irq_mode           <= 2'b00;
            tx_idle_invert        <= 1'b0;
            send_break            <= 1'b0;
            tx_enable             <= 1'b0;
            rx_irq_mode           <= 2'b00;
            address_detect_enable <= 1'b0;
            overrun_error         <= 1'b0;
            port_enable           <= 1'b0;
            infrared_encoder_on   <= 1'b0;
            irq_stat              <= 2'b00;
            irq_mask              <= 2'b00;
        end else begin
            if (wr & hit_sta) begin
                tx_irq_mode           <= {pwdata[`USC_B_TXI_HI], pwdata[`USC_B_TXI_LO]};
                tx_idle_invert        <= pwdata[`USC_B_TXINV];
                tx_enable             <= pwdata[`USC_B_TXEN];
                rx_irq_mode           <= {pwdata[`USC_B_RXI_HI], pwdata[`USC_B_RXI_LO]};
                address_detect_enable <= pwdata[`USC_B_ADDRESS_DETECT_ENABLE];
                send_break            <= pwdata[`USC_B_BRK];
                if (!pwdata[`USC_B_OVERRUN_ERROR]) begin
                    overrun_error <= 1'b0;
                end
            end else if (tx_done & tx_is_break) begin
                send_break <= 1'b0;
            end
            if (rx_push & rx_full) begin
                overrun_error <= 1'b1;
            end
            if (wr & hit_ctl) begin
                port_enable         <= pwdata[`USC_B_PEN];
                infrared_encoder_on <= pwdata[`USC_B_INFRARED_ENCODER_ON];
            end
            if (wr & hit_imk) begin
                irq_mask <= pwdata[1:0];
            end
            // set wins over write-one-to-clear
            irq_stat <= ((wr & hit_ist) ? (irq_stat & ~pwdata[1:0]) : irq_stat)
                        | {rx_event, tx_event};
        end
    end

    // ----------------------------------------------------------------
    // read data
    // ----------------------------------------------------------------
    wire [15:0] sta_word = {tx_irq_mode[1], tx_idle_invert, tx_irq_mode[0], 1'b0,
                            send_break, tx_enable,
                            tx_buffer_full, tx_shift_empty,
                            rx_irq_mode, address_detect_enable, receiver_idle,
                            1'b0, framing_error, overrun_error, rx_data_available};
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel & ~penable & ~pwrite) begin
            case (paddr)
                `USC_OFS_STA:      prdata <= {16'h0000, sta_word};
                `USC_OFS_RXDATA:   prdata <= {24'h000000, rx_head};
                `USC_OFS_IRQ_STAT: prdata <= {30'h0, irq_stat};
                `USC_OFS_IRQ_MASK: prdata <= {30'h0, irq_mask};
                `USC_OFS_CTRL:     prdata <= {30'h0, infrared_encoder_on, port_enable};
                default:           prdata <= 32'h0000_0000;
            endcase
        end
    end
endmodule // usc_uart

// file: verif/usc_peer.sv
// remote serial node: sends and decodes 8n1 frames, measures low runs
// assumes idle-high lines, BIT pclk cycles a bit
`timescale 1ns/10ps
module usc_peer #(
    parameter BIT = 8
) (
    input  wire pclk,
    input  wire line_in,
    output reg  line_out
);
    reg [7:0] got [$];
    reg [7:0] sh;
    integer   low_run, max_low, i;
    initial begin
        line_out = 1'b1;
        low_run  = 0;
        max_low  = 0;
    end
    always @(posedge pclk) begin
        low_run <= line_in ? 0 : low_run + 1;
        if (!line_in && low_run + 1 > max_low)
            max_low <= low_run + 1;
    end
    // stop bit unchecked: a break decodes as zero
    initial forever begin
        @(negedge line_in);
        repeat (BIT / 2) @(posedge pclk);
        for (i = 0; i < 8; i = i + 1) begin
            repeat (BIT) @(posedge pclk);
            sh = {line_in, sh[7:1]};
        end
        repeat (BIT) @(posedge pclk);
        got.push_back(sh);
    end
    task send(input [7:0] b, input integer gap);
        integer   k;
        reg [9:0] fr;
        begin
            fr = {1'b1, b, 1'b0};
            for (k = 0; k < 10; k = k + 1) begin
                @(posedge pclk);
                line_out <= fr[k];
                repeat (BIT - 1) @(posedge pclk);
            end
            repeat (gap) @(posedge pclk);
        end
    endtask
endmodule // usc_peer

// file: verif/usc_uart_assertions.sv
// checker for usc_uart: apb, pin, bit timing, irq
// assumes one pclk domain; bound to the top by port names
`timescale 1ns/10ps
module usc_uart_assertions #(
    parameter BIT_CYC = 8
) (
    input wire        pclk,
    input wire        presetn,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire        pready,
    input wire        pslverr,
    input wire        gpio_out,
    input wire        serial_out_pin,
    input wire        irq
);
    // ----------------------------------------------------------------
    // shadow of written control bits
    // ----------------------------------------------------------------
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    reg         txen_h, pen_h, infrared_encoder_on_h, quiet, mask_z;
    reg  [15:0] low_cnt;
    wire        wr  = psel && penable && pwrite && pready;
    wire        own = txen_h && pen_h && !infrared_encoder_on_h;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            txen_h <= 1'b0;
            pen_h  <= 1'b0;
            infrared_encoder_on_h <= 1'b0;
            quiet  <= 1'b1;
            mask_z <= 1'b1;
        end else if (wr) begin
            if (paddr == 12'h000) begin
                txen_h <= pwdata[10];
                quiet  <= 1'b1;
            end
            if (paddr == 12'h004) quiet <= 1'b0;
            if (paddr == 12'h010) mask_z <= (pwdata[1:0] == 2'b00);
            if (paddr == 12'h014) begin
                pen_h  <= pwdata[0];
                infrared_encoder_on_h <= pwdata[1];
            end
        end
    end
    // encoder on lets idle invert flip the line, so runs count only with it off
    always @(posedge pclk or negedge presetn) begin
        if (!presetn)
            low_cnt <= 16'h0000;
        else if (!own || serial_out_pin)
            low_cnt <= 16'h0000;
        else
            low_cnt <= low_cnt + 16'h0001;
    end
    sequence s_txoff;
        wr && paddr == 12'h000 && !pwdata[10];
    endsequence
    sequence s_txwr;
        wr && paddr == 12'h004 && quiet && own;
    endsequence
    AST_GPIO_PIN: assert property (!txen_h |-> serial_out_pin == gpio_out)
        else $error("gpio not on pin");
    AST_ABORT_PIN: assert property (s_txoff |=> (serial_out_pin == gpio_out) [*4])
        else $error("pin kept on abort");
    AST_IDLE_HIGH: assert property (quiet && own |-> serial_out_pin)
        else $error("idle not high");
    AST_TX_START: assert property (s_txwr |-> ##[1:3] !serial_out_pin)
        else $error("no start bit");
    AST_LOW_BITS: assert property ($rose(serial_out_pin) && own |-> low_cnt % BIT_CYC == 0)
        else $error("low run not whole bits");
    AST_LOW_MAX: assert property (low_cnt <= 13 * BIT_CYC)
        else $error("low run too long");
    AST_SLVERR: assert property (psel && penable && paddr >= 12'h018 |-> pslverr)
        else $error("unmapped not refused");
    AST_NO_SLVERR: assert property (psel && penable && paddr[1:0] == 2'b00
        && paddr <= 12'h014 |-> !pslverr)
        else $error("mapped access refused");
    AST_IRQ_GATED: assert property (mask_z |-> !irq)
        else $error("irq while masked");
endmodule // usc_uart_assertions

bind usc_uart usc_uart_assertions #(
    .BIT_CYC(BIT_CYC)
) u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .pslverr(pslverr), .gpio_out(gpio_out), .serial_out_pin(serial_out_pin), .irq(irq)
);

// file: verif/usc_uart_tb.sv
// self-checking bench for usc_uart with a serial peer
// assumes a short bit time and the bound checker
`timescale 1ns/10ps
module usc_uart_tb;
    localparam BIT = 8;
    reg         pclk, presetn, psel, penable, pwrite, gpio_out, se, p1;
    reg  [11:0] paddr;
    reg  [31:0] pwdata, rd, rnd;
    wire [31:0] prdata;
    wire        pready, pslverr, sin, sout, irq;
    integer     errors, cmp_count, m, k, n;
    reg  [7:0]  exp_q [$];
    usc_uart #(.BIT_CYC(BIT), .TX_DEPTH(4)) dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .serial_in_pin(sin),
        .gpio_out(gpio_out), .serial_out_pin(sout), .irq(irq)
    );
    usc_peer #(.BIT(BIT)) u_peer (.pclk(pclk), .line_in(sout), .line_out(sin));
    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function [31:0] lfsr(input [31:0] s);
        lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function integer rx_thr(input integer md);
        rx_thr = (md == 3) ? 4 : (md == 2) ? 3 : 1;
    endfunction
    function [31:0] txmode(input integer md);
        txmode = {16'h0, md[1], 1'b0, md[0], 3'h1, 10'h0};
    endfunction
    task chk(input [31:0] got, input [31:0] exp);
        begin
            cmp_count = cmp_count + 1;
            if (got !== exp) begin
                $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
                errors = errors + 1;
            end
        end
    endtask
    task apb(input w, input [11:0] a, input [31:0] d);
        integer t;
        begin
            @(posedge pclk);
            psel    <= 1'b1;
            penable <= 1'b0;
            pwrite  <= w;
            paddr   <= a;
            pwdata  <= d;
            @(posedge pclk);
            penable <= 1'b1;
            t = 0;
            do begin
                @(posedge pclk);
                t = t + 1;
            end while (pready !== 1'b1 && t < 20);
            errors = errors + (t >= 20);
            rd = prdata;
            se = pslverr;
            psel    <= 1'b0;
            penable <= 1'b0;
        end
    endtask
    task rdm(input [11:0] a, input [31:0] msk, input [31:0] e);
        begin
            apb(1'b0, a, 32'h0);
            chk(rd & msk, e);
        end
    endtask
    task wait_idle;
        integer t;
        begin
            t = 0;
            rd = 32'h0;
            while (rd[8] !== 1'b1 && t < 400) begin
                apb(1'b0, 12'h000, 32'h0);
                t = t + 1;
            end
            errors = errors + (t >= 400);
            repeat (BIT) @(posedge pclk);
        end
    endtask
    task cmp_q;
        begin
            chk(u_peer.got.size(), exp_q.size());
            while (exp_q.size() > 0 && u_peer.got.size() > 0)
                chk(u_peer.got.pop_front(), exp_q.pop_front());
            exp_q.delete();
            u_peer.got.delete();
        end
    endtask
    task final_report;
        begin
            $display("compares %0d errors %0d", cmp_count, errors);
            if (errors == 0 && cmp_count > 0)
                $display("*** PASS ***");
            else
                $display("*** FAIL ***");
            $finish;
        end
    endtask
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    // the run needs under a third of this
    initial begin
        repeat (30000) @(posedge pclk);
        errors = errors + 1;
        final_report;
    end
    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = 0;
        gpio_out = 1'b1;
        errors = 0;
        cmp_count = 0;
        rnd = 32'hcccb;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        rdm(12'h000, ~32'h0, 32'h110);
        for (k = 3; k < 6; k = k + 1)
            rdm(12'(4 * k), ~32'h0, 32'h0);
        apb(1'b1, 12'h040, 32'hffff);
        chk(se, 1);
        rdm(12'h040, ~32'h0, 32'h0);
        chk(se, 1);
        for (k = 0; k < 8; k = k + 1) begin
            rnd = lfsr(rnd);
            @(posedge pclk);
            gpio_out <= rnd[0];
            #1 chk(sout, gpio_out);
        end
        @(posedge pclk);
        gpio_out <= 1'b1;
        apb(1'b1, 12'h014, 32'h1);
        apb(1'b1, 12'h000, 32'h4400);
        @(negedge pclk);
        chk(sout, 1);
        apb(1'b1, 12'h014, 32'h3);
        @(negedge pclk);
        p1 = sout;
        apb(1'b1, 12'h000, 32'h0400);
        @(negedge pclk);
        chk(sout ^ p1, 1);
        repeat (10 * BIT) @(posedge pclk);
        u_peer.got.delete();
        apb(1'b1, 12'h014, 32'h1);
        for (k = 0; k < 6; k = k + 1) begin
            rnd = lfsr(rnd);
            if (k < 5)
                exp_q.push_back(rnd[7:0]);
            apb(1'b1, 12'h004, {24'h0, rnd[7:0]});
        end
        rdm(12'h000, 32'h300, 32'h200);
        wait_idle;
        rdm(12'h000, 32'h300, 32'h100);
        cmp_q;
        u_peer.max_low = 0;
        apb(1'b1, 12'h000, 32'h0c00);
        apb(1'b1, 12'h004, 32'h5a);
        rdm(12'h000, 32'h900, 32'h800);
        wait_idle;
        rdm(12'h000, 32'h800, 32'h0);
        chk(u_peer.max_low, 13 * BIT);
        u_peer.got.delete();
        exp_q.push_back(8'h81);
        apb(1'b1, 12'h004, 32'h81);
        wait_idle;
        cmp_q;
        for (k = 0; k < 3; k = k + 1)
            apb(1'b1, 12'h004, 32'ha5);
        repeat (3 * BIT) @(posedge pclk);
        apb(1'b1, 12'h000, 32'h0);
        rdm(12'h000, 32'h700, 32'h100);
        repeat (12 * BIT) @(posedge pclk);
        u_peer.got.delete();
        apb(1'b1, 12'h000, 32'h0400);
        repeat (12 * BIT) @(posedge pclk);
        cmp_q;
        apb(1'b1, 12'h010, 32'h1);
        for (m = 0; m < 4; m = m + 1) begin
            apb(1'b1, 12'h000, txmode(m));
            apb(1'b1, 12'h00c, 32'h3);
            apb(1'b1, 12'h004, 32'h3c);
            repeat (2) @(posedge pclk);
            rdm(12'h00c, 32'h1, (m == 0 || m == 2) ? 32'h1 : 32'h0);
            wait_idle;
            rdm(12'h00c, 32'h1, (m != 3) ? 32'h1 : 32'h0);
            chk(irq, m != 3);
        end
        u_peer.got.delete();
        apb(1'b1, 12'h010, 32'h2);
        for (m = 0; m < 4; m = m + 1) begin
            apb(1'b1, 12'h000, 32'h400 | (m << 6));
            apb(1'b1, 12'h00c, 32'h3);
            n = rx_thr(m);
            for (k = 0; k < n; k = k + 1) begin
                if (k == n - 1)
                    rdm(12'h00c, 32'h2, 32'h0);
                rnd = lfsr(rnd);
                exp_q.push_back(rnd[7:0]);
                u_peer.send(rnd[7:0], BIT + rnd[12:9]);
            end
            rdm(12'h00c, 32'h2, 32'h2);
            chk(irq, 1);
            for (k = 0; k < n; k = k + 1)
                rdm(12'h008, ~32'h0, {24'h0, exp_q.pop_front()});
            apb(1'b1, 12'h00c, 32'h2);
            @(negedge pclk);
            chk(irq, 0);
        end
        final_report;
    end
endmodule // usc_uart_tb
